/* File: src/emb_bus.sv */
// external memory bus pins: async memory cycles and 16-bit sdram cycles
`timescale 1ns/1ps
`default_nettype none
`include "emb_map.svh"

module emb_bus
	import emb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	// core request side
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic        req_byte,
	input  wire logic [25:0] req_addr,
	input  wire logic [15:0] req_wdata,
	output logic             req_ready_ff,
	output logic             resp_valid_ff,
	output logic [15:0]      resp_rdata_ff,
	// decode and port width configuration
	input  wire logic [1:0]  cs_en,
	input  wire logic [2:0]  cs0_base,
	input  wire logic [2:0]  cs1_base,
	input  wire logic [1:0]  cs_wide,
	input  wire logic [1:0]  bank_en,
	input  wire logic        dflt_wide,
	// shared pin function select and gpio side
	input  wire logic [2:0]  func_gpio,
	input  wire logic [2:0]  gpio_out,
	input  wire logic [2:0]  gpio_oe,
	output logic [2:0]       gpio_in_ff,
	// memory bus pins
	output logic [23:1]      ext_addr_ff,
	output logic             ext_rd_wr_ff,
	output logic             ext_oe_n_ff,
	input  wire logic [15:0] data_in,
	output logic [15:0]      data_out_ff,
	output logic             data_oe_ff,
	output logic             sdram_row_strobe_n_ff,
	output logic             sdram_col_strobe_n_ff,
	output logic             sdram_write_en_n_ff,
	output logic             sdram_select_0_n_ff,
	output logic             sdram_upper_mask_ff,
	output logic             sdram_lower_mask_ff,
	output logic             sdram_clk_ff,
	output logic             sdram_clock_en_ff,
	// shared pins: address bit 25, second sdram select, transfer ack
	input  wire logic [2:0]  shared_pin_in,
	output logic [2:0]       shared_pin_out_ff,
	output logic [2:0]       shared_pin_oe_ff
);

	emb_state_t  state_ff;
	emb_state_t  nxt_state;
	logic        wr_ff;
	logic        byte_ff;
	logic        wide_ff;
	logic [25:0] addr_ff;
	logic [15:0] wdata_ff;
	logic [2:0]  func_gpio_ff;

	// width selection from a port width flag
	function automatic logic [15:0] lane_read(input logic wide, input logic [15:0] d);
		lane_read = wide ? d : {8'h00, d[15:8]};
	endfunction

	// bus edge: the mclk edge that ends the sdram clock high phase, where the sdram clock falls
	wire logic tick = sdram_clk_ff;
	wire logic take = (state_ff == EMB_IDLE) && tick && req_valid;

	// address decode: chip selects, sdram banks, else default config
	wire logic [2:0] cs_field = req_addr[`EMB_CS_MSB:`EMB_CS_LSB];
	wire logic       cs0_hit  = cs_en[0] && (cs_field == cs0_base);
	wire logic       cs1_hit  = cs_en[1] && !cs0_hit && (cs_field == cs1_base);
	wire logic       sd_hit   = bank_en[req_addr[`EMB_BANK_BIT]];
	wire logic       hit_wide = cs0_hit ? cs_wide[0] : cs1_hit ? cs_wide[1] : dflt_wide;

	// latched request for the cycle in flight
	wire logic        nxt_wr    = take ? req_write : wr_ff;
	wire logic        nxt_byte  = take ? req_byte : byte_ff;
	wire logic [25:0] nxt_addr  = take ? req_addr : addr_ff;
	wire logic [15:0] nxt_wdata = take ? req_wdata : wdata_ff;

	// async cycle ends on the acknowledge seen through the shared pin
	wire logic tack = !gpio_in_ff[`EMB_PIN_TACK];

	// sequencer: async wait, or sdram activate, column, done
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			EMB_IDLE:  if (take) nxt_state = sd_hit ? EMB_ACT : EMB_ASYNC;
			EMB_ASYNC: if (tick && tack) nxt_state = EMB_IDLE;
			EMB_ACT:   if (tick) nxt_state = EMB_CAS;
			EMB_CAS:   if (tick) nxt_state = EMB_DONE;
			EMB_DONE:  if (tick) nxt_state = EMB_IDLE;
			default:   nxt_state = EMB_IDLE;
		endcase
	end

	wire logic n_async = (nxt_state == EMB_ASYNC);
	wire logic n_act   = (nxt_state == EMB_ACT);
	wire logic n_cas   = (nxt_state == EMB_CAS);
	wire logic n_busy  = (nxt_state != EMB_IDLE);
	wire logic n_sd    = n_act || n_cas || (nxt_state == EMB_DONE);

	// address lines: byte address for async, row then column for sdram
	wire logic [23:1] row_addr = {{(23-`EMB_ROW_W){1'b0}}, nxt_addr[`EMB_ROW_MSB:`EMB_ROW_LSB]};
	wire logic [23:1] col_addr = {{(23-`EMB_COL_W){1'b0}}, nxt_addr[`EMB_COL_MSB:`EMB_COL_LSB]};
	wire logic [23:1] nxt_ext_addr = n_act ? row_addr : n_cas ? col_addr : nxt_addr[23:1];

	// data: a byte goes out on both lanes so all 16 lines carry it
	wire logic [15:0] nxt_dout = nxt_byte ? {nxt_wdata[7:0], nxt_wdata[7:0]} : nxt_wdata;
	wire logic        nxt_doe  = nxt_wr && (n_async || n_cas);

	// byte masks: even byte address is the upper lane
	wire logic nxt_umask = n_cas && nxt_byte && nxt_addr[0];
	wire logic nxt_lmask = n_cas && nxt_byte && !nxt_addr[0];

	// completion: async on acknowledge, sdram one bus edge after column
	wire logic done = tick && ((state_ff == EMB_ASYNC && tack) || state_ff == EMB_DONE);

	// primary sources of the shared pins
	wire logic [2:0] prim_out = {1'b1, !(n_sd && nxt_addr[`EMB_BANK_BIT]), nxt_addr[25]};
	wire logic [2:0] prim_oe  = 3'b011;

	emb_pin_mux u_mux (
		.mclk         (mclk),
		.reset        (reset),
		.func_gpio    (func_gpio),
		.prim_out     (prim_out),
		.prim_oe      (prim_oe),
		.gpio_out     (gpio_out),
		.gpio_oe      (gpio_oe),
		.pin_in       (shared_pin_in),
		.pin_out_ff   (shared_pin_out_ff),
		.pin_oe_ff    (shared_pin_oe_ff),
		.gpio_in_ff   (gpio_in_ff),
		.func_gpio_ff (func_gpio_ff)
	);

	// request latch, state and handshake
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_ff      <= EMB_IDLE;
			wr_ff         <= 1'b0;
			byte_ff       <= 1'b0;
			wide_ff       <= 1'b0;
			addr_ff       <= 26'h0;
			wdata_ff      <= 16'h0;
			req_ready_ff  <= 1'b0;
			resp_valid_ff <= 1'b0;
			resp_rdata_ff <= 16'h0;
		end else begin
			state_ff      <= nxt_state;
			wr_ff         <= nxt_wr;
			byte_ff       <= nxt_byte;
			wide_ff       <= take ? (sd_hit || hit_wide) : wide_ff;
			addr_ff       <= nxt_addr;
			wdata_ff      <= nxt_wdata;
			req_ready_ff  <= take;
			resp_valid_ff <= done;
			if (done && !wr_ff)
				resp_rdata_ff <= lane_read(wide_ff, data_in);
		end
	end

	// bus clock divider and clock enable
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sdram_clk_ff      <= 1'b0;
			sdram_clock_en_ff <= 1'b0;
		end else begin
			sdram_clk_ff      <= !sdram_clk_ff;
			sdram_clock_en_ff <= 1'b1;
		end
	end

	// registered pin drivers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ext_addr_ff           <= 23'h0;
			ext_rd_wr_ff          <= 1'b1;
			ext_oe_n_ff           <= 1'b1;
			data_out_ff           <= 16'h0;
			data_oe_ff            <= 1'b0;
			sdram_row_strobe_n_ff <= 1'b1;
			sdram_col_strobe_n_ff <= 1'b1;
			sdram_write_en_n_ff   <= 1'b1;
			sdram_select_0_n_ff   <= 1'b1;
			sdram_upper_mask_ff   <= 1'b0;
			sdram_lower_mask_ff   <= 1'b0;
		end else begin
			ext_addr_ff           <= nxt_ext_addr;
			ext_rd_wr_ff          <= !(n_busy && nxt_wr);
			ext_oe_n_ff           <= !(n_async && !nxt_wr);
			data_out_ff           <= nxt_dout;
			data_oe_ff            <= nxt_doe;
			sdram_row_strobe_n_ff <= !n_act;
			sdram_col_strobe_n_ff <= !n_cas;
			sdram_write_en_n_ff   <= !(n_cas && nxt_wr);
			sdram_select_0_n_ff   <= !(n_sd && !nxt_addr[`EMB_BANK_BIT]);
			sdram_upper_mask_ff   <= nxt_umask;
			sdram_lower_mask_ff   <= nxt_lmask;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_row;
		!sdram_row_strobe_n_ff && sdram_col_strobe_n_ff;
	endsequence
	sequence s_col;
		sdram_row_strobe_n_ff && !sdram_col_strobe_n_ff;
	endsequence

	addr_byte_a: assert property (state_ff == EMB_ASYNC |-> ext_addr_ff == addr_ff[23:1])
		else $error("async address not the latched byte address");
	row_col_seq_a: assert property ($fell(sdram_row_strobe_n_ff) |-> s_row [*2] ##1 s_col)
		else $error("row then column order broken");
	rw_level_a: assert property (state_ff != EMB_IDLE |-> ext_rd_wr_ff == !wr_ff)
		else $error("read/write line wrong during cycle");
	oe_read_a: assert property (!ext_oe_n_ff |-> state_ff == EMB_ASYNC && !wr_ff)
		else $error("output enable outside an async read");
	rdata_take_a: assert property (done && !wr_ff && wide_ff |=> resp_rdata_ff == $past(data_in))
		else $error("read data not taken on the edge");
	write_drive_a: assert property (state_ff == EMB_ASYNC && wr_ff |-> data_oe_ff)
		else $error("write not driving data lines");
	we_read_a: assert property (!sdram_col_strobe_n_ff && !wr_ff |-> sdram_write_en_n_ff)
		else $error("sdram write enable low on a read");
	mask_byte_a: assert property (sdram_upper_mask_ff |-> !sdram_col_strobe_n_ff && byte_ff)
		else $error("byte mask outside a byte column cycle");
	clk_toggle_a: assert property (sdram_clk_ff |=> !sdram_clk_ff)
		else $error("bus clock not toggling");
	cke_high_a: assert property ($rose(sdram_clock_en_ff) |=> sdram_clock_en_ff [*4])
		else $error("sdram clock enable dropped");
	sel0_bank_a: assert property (!sdram_select_0_n_ff |-> !addr_ff[`EMB_BANK_BIT])
		else $error("select 0 asserted for bank 1");

	// sdram column step of a write
	sequence s_write_col;
		!sdram_col_strobe_n_ff && wr_ff;
	endsequence
	// second select low while its pin is in primary function
	sequence s_sel1_low;
		!func_gpio_ff[`EMB_PIN_SEL1] && shared_pin_oe_ff[`EMB_PIN_SEL1]
			&& !shared_pin_out_ff[`EMB_PIN_SEL1];
	endsequence

	row_on_addr_a: assert property (s_row |->
		ext_addr_ff[14:1] == addr_ff[`EMB_ROW_MSB:`EMB_ROW_LSB])
		else $error("row address not on the address lines");
	col_on_addr_a: assert property (s_col |->
		ext_addr_ff[10:1] == addr_ff[`EMB_COL_MSB:`EMB_COL_LSB])
		else $error("column address not on the address lines");
	strobe_excl_a: assert property (!(!sdram_row_strobe_n_ff && !sdram_col_strobe_n_ff))
		else $error("row and column strobes low together");
	we_write_a: assert property (s_write_col |-> !sdram_write_en_n_ff)
		else $error("sdram write enable high on a write");
	sd_write_drive_a: assert property (s_write_col |-> data_oe_ff)
		else $error("sdram write not driving data lines");
	byte_lanes_a: assert property (data_oe_ff && byte_ff |->
		data_out_ff[15:8] == data_out_ff[7:0])
		else $error("byte write not on both lanes");
	lmask_byte_a: assert property (sdram_lower_mask_ff |->
		!sdram_col_strobe_n_ff && byte_ff)
		else $error("lower mask outside a byte column cycle");
	idle_read_a: assert property (state_ff == EMB_IDLE |-> ext_rd_wr_ff)
		else $error("read/write line low while idle");
	narrow_read_a: assert property (done && !wr_ff && !wide_ff |=>
		resp_rdata_ff[15:8] == 8'h00)
		else $error("narrow read upper byte not cleared");
	sel1_bank_a: assert property (s_sel1_low |-> addr_ff[`EMB_BANK_BIT]
		&& state_ff != EMB_IDLE && state_ff != EMB_ASYNC)
		else $error("select 1 asserted outside a bank 1 cycle");
	addr_hi_pin_a: assert property (!func_gpio_ff[`EMB_PIN_ADDR_HI] |->
		shared_pin_out_ff[`EMB_PIN_ADDR_HI] == addr_ff[`EMB_BANK_BIT])
		else $error("address bit 25 pin not following the address");

endmodule
`default_nettype wire

/* File: src/emb_map.svh */
// offsets, field positions and reset values of the external memory bus
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH

// sdram address split: bank bit, row and column fields of the byte address
`define EMB_BANK_BIT     25
`define EMB_ROW_MSB      24
`define EMB_ROW_LSB      11
`define EMB_ROW_W        14
`define EMB_COL_MSB      10
`define EMB_COL_LSB      1
`define EMB_COL_W        10
// chip select base compare field of the byte address
`define EMB_CS_MSB       25
`define EMB_CS_LSB       23
// positions of the shared pins in the gpio mux vector
`define EMB_PIN_ADDR_HI  0
`define EMB_PIN_SEL1     1
`define EMB_PIN_TACK     2
`define EMB_NUM_SHARED   3
// reset value of the function select: all shared pins in primary function
`define EMB_FUNC_RESET   3'h0
// bus clock is the system clock halved; one bus edge every two mclk cycles
`define EMB_MCLK_NS      50
`define EMB_BUS_DIV      2

`endif

/* File: src/emb_pkg.sv */
// types shared by the external memory bus files
package emb_pkg;

	// bus sequencer states
	typedef enum logic [2:0] {
		EMB_IDLE  = 3'b000,
		EMB_ASYNC = 3'b001,
		EMB_ACT   = 3'b010,
		EMB_CAS   = 3'b011,
		EMB_DONE  = 3'b100
	} emb_state_t;

	// operand size
	typedef enum logic {
		EMB_SZ_WORD = 1'b0,
		EMB_SZ_BYTE = 1'b1
	} emb_size_t;

endpackage

/* File: src/emb_pin_mux.sv */
// function select for pins shared between a bus function and gpio
`timescale 1ns/1ps
`default_nettype none
`include "emb_map.svh"

module emb_pin_mux
	import emb_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       reset,
	input  wire logic [`EMB_NUM_SHARED-1:0] func_gpio,
	input  wire logic [`EMB_NUM_SHARED-1:0] prim_out,
	input  wire logic [`EMB_NUM_SHARED-1:0] prim_oe,
	input  wire logic [`EMB_NUM_SHARED-1:0] gpio_out,
	input  wire logic [`EMB_NUM_SHARED-1:0] gpio_oe,
	input  wire logic [`EMB_NUM_SHARED-1:0] pin_in,
	output logic      [`EMB_NUM_SHARED-1:0] pin_out_ff,
	output logic      [`EMB_NUM_SHARED-1:0] pin_oe_ff,
	output logic      [`EMB_NUM_SHARED-1:0] gpio_in_ff,
	output logic      [`EMB_NUM_SHARED-1:0] func_gpio_ff
);

	// pick the source of each pin from the live select input, not the held copy
	wire logic [`EMB_NUM_SHARED-1:0] nxt_pin_out = (func_gpio & gpio_out) | (~func_gpio & prim_out);
	wire logic [`EMB_NUM_SHARED-1:0] nxt_pin_oe  = (func_gpio & gpio_oe) | (~func_gpio & prim_oe);

	// select comes up primary; gpio input sampled whatever the function
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			func_gpio_ff <= `EMB_FUNC_RESET;
			pin_out_ff   <= 3'h0;
			pin_oe_ff    <= 3'h0;
			gpio_in_ff   <= 3'h0;
		end else begin
			func_gpio_ff <= func_gpio;
			pin_out_ff   <= nxt_pin_out;
			pin_oe_ff    <= nxt_pin_oe;
			gpio_in_ff   <= pin_in;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// first edge after reset still shows reset values, not last cycle's pins
	gpio_in_live_a: assert property (!$past(reset) |-> gpio_in_ff == $past(pin_in))
		else $error("gpio input path not following the pin");
	pin_src_sel_a: assert property (!$past(reset) |-> pin_out_ff ==
		(($past(func_gpio) & $past(gpio_out)) | (~$past(func_gpio) & $past(prim_out))))
		else $error("shared pin driven from the wrong source");
	reset_primary_a: assert property ($fell(reset) |-> func_gpio_ff == 3'h0)
		else $error("shared pin not primary after reset");

endmodule
`default_nettype wire

/* File: tb/emb_mem_model.sv */
// far side model: async memory with wait states and sdram read data
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model #(
	parameter logic [15:0] RD_PAT = 16'ha55c
) (
	input  wire logic        mclk,
	input  wire logic        ext_oe_n,
	input  wire logic        data_oe,
	input  wire logic        sel_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [3:0]  wait_cyc,
	output logic      [15:0] data_in,
	output logic             ack_n
);
	logic [3:0] cnt_ff = 4'h0;
	logic [2:0] hold_ff = 3'h0;
	wire logic  async_cyc;

	assign async_cyc = (!ext_oe_n || data_oe) && sel_n;
	// wait states counted, sdram data held a few cycles after the column strobe
	always_ff @(posedge mclk) begin
		cnt_ff <= async_cyc ? cnt_ff + 4'h1 : 4'h0;
		hold_ff <= (!cas_n && we_n) ? 3'h6 : hold_ff - 3'(hold_ff != 3'h0);
	end
	// acknowledge high until the wait count is reached, then low to end the cycle
	assign ack_n = !(async_cyc && cnt_ff >= wait_cyc);
	// released lines show the inverse pattern, never a stale value
	assign data_in = (!ext_oe_n || hold_ff != 3'h0) ? RD_PAT : ~RD_PAT;
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the external memory bus pins
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import emb_pkg::*;
	localparam logic [15:0] RD_PAT = 16'ha55c;
	logic mclk = 1'b0, reset = 1'b1;
	logic req_valid, req_write, req_byte, dflt_wide;
	logic [25:0] req_addr;
	logic [15:0] req_wdata, resp_rdata_ff, data_in, data_out_ff, dout;
	logic req_ready_ff, resp_valid_ff, ext_rd_wr_ff, ext_oe_n_ff, data_oe_ff, ack_n;
	logic [1:0] cs_en, cs_wide, bank_en, pin_drv;
	logic [2:0] cs0_base, cs1_base, func_gpio, gpio_out, gpio_oe, gpio_in_ff;
	logic [2:0] shared_pin_out_ff, shared_pin_oe_ff;
	logic [23:1] ext_addr_ff, row_a, col_a, oe_a;
	logic row_n, col_n, we_n, sel0_n, um_ff, lm_ff, sclk, cke;
	logic saw_oe, saw_wr, saw_we, saw_sel, saw_s1, um, lm;
	logic [3:0] wait_cyc;
	wire logic [2:0] pin_lvl;
	int err_total = 0, n_tests = 0, ncyc;

	always #25 mclk = ~mclk;
	// shared pin levels from design enables, bench drive and acknowledge
	assign pin_lvl[1:0] = (shared_pin_oe_ff[1:0] & shared_pin_out_ff[1:0])
		| (~shared_pin_oe_ff[1:0] & pin_drv);
	assign pin_lvl[2] = shared_pin_oe_ff[2] ? shared_pin_out_ff[2] : ack_n;

	emb_bus u_emb_bus (.mclk(mclk), .reset(reset), .req_valid(req_valid),
		.req_write(req_write), .req_byte(req_byte), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready_ff(req_ready_ff), .resp_valid_ff(resp_valid_ff),
		.resp_rdata_ff(resp_rdata_ff), .cs_en(cs_en), .cs0_base(cs0_base),
		.cs1_base(cs1_base), .cs_wide(cs_wide), .bank_en(bank_en), .dflt_wide(dflt_wide),
		.func_gpio(func_gpio), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.gpio_in_ff(gpio_in_ff), .ext_addr_ff(ext_addr_ff), .ext_rd_wr_ff(ext_rd_wr_ff),
		.ext_oe_n_ff(ext_oe_n_ff), .data_in(data_in), .data_out_ff(data_out_ff),
		.data_oe_ff(data_oe_ff), .sdram_row_strobe_n_ff(row_n),
		.sdram_col_strobe_n_ff(col_n), .sdram_write_en_n_ff(we_n),
		.sdram_select_0_n_ff(sel0_n), .sdram_upper_mask_ff(um_ff),
		.sdram_lower_mask_ff(lm_ff), .sdram_clk_ff(sclk), .sdram_clock_en_ff(cke),
		.shared_pin_in(pin_lvl), .shared_pin_out_ff(shared_pin_out_ff),
		.shared_pin_oe_ff(shared_pin_oe_ff));

	emb_mem_model #(.RD_PAT(RD_PAT)) u_emb_mem_model (.mclk(mclk), .ext_oe_n(ext_oe_n_ff),
		.data_oe(data_oe_ff), .sel_n(sel0_n & pin_lvl[1]), .cas_n(col_n), .we_n(we_n),
		.wait_cyc(wait_cyc), .data_in(data_in), .ack_n(ack_n));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus transfer, recording what the pins showed on the way
	task automatic xfer(input logic w, input logic b, input logic [25:0] a,
		input logic [15:0] d);
		logic rdy, done;
		{rdy, done, saw_oe, saw_wr, saw_we, saw_sel, saw_s1, um, lm} = 9'h0;
		ncyc = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_byte <= b;
		req_addr <= a;
		req_wdata <= d;
		while (!done && ncyc < 40) begin
			@(posedge mclk);
			if (rdy)
				req_valid <= 1'b0;
			#1;
			ncyc++;
			rdy = rdy | (req_ready_ff === 1'b1);
			if (!row_n)
				row_a = ext_addr_ff;
			if (!col_n) begin
				col_a = ext_addr_ff;
				{um, lm} = {um_ff, lm_ff};
			end
			if (!ext_oe_n_ff)
				oe_a = ext_addr_ff;
			if (data_oe_ff)
				dout = data_out_ff;
			saw_oe |= !ext_oe_n_ff;
			saw_wr |= !ext_rd_wr_ff;
			saw_we |= !we_n;
			saw_sel |= !sel0_n;
			saw_s1 |= !pin_lvl[1];
			done = (resp_valid_ff === 1'b1);
		end
		if (!done) begin
			err_total++;
			end_of_test();
		end
		repeat (2) @(posedge mclk);
	endtask

	task automatic t_reset();
		logic c0;
		@(posedge mclk);
		#1;
		chk(16'(shared_pin_oe_ff), 16'h3);
		chk(16'(cke), 16'h1);
		c0 = sclk;
		@(posedge mclk);
		#1;
		chk(16'(sclk), 16'(!c0));
	endtask

	task automatic t_sdram();
		xfer(1'b0, 1'b0, 26'h2abcde6, 16'h0);
		chk(16'(row_a[14:1]), 16'h1579);
		chk(16'(col_a[10:1]), 16'h2f3);
		chk(16'({saw_s1, saw_sel, saw_we, saw_oe}), 16'h8);
		chk(resp_rdata_ff, RD_PAT);
		chk(16'(shared_pin_out_ff[0]), 16'h1);
		xfer(1'b1, 1'b0, 26'h2000020, 16'h3c5a);
		chk(16'({saw_we, um, lm}), 16'h4);
		chk(dout, 16'h3c5a);
		xfer(1'b1, 1'b1, 26'h2000010, 16'h0077);
		chk(16'({um, lm}), 16'h1);
		chk(dout, 16'h7777);
		xfer(1'b1, 1'b1, 26'h2000011, 16'h0042);
		chk(16'({um, lm}), 16'h2);
		chk(dout, 16'h4242);
		// bank 0 enabled for one read, then back off for the async scenario
		bank_en <= 2'b11;
		xfer(1'b0, 1'b0, 26'h0000100, 16'h0);
		chk(16'({saw_s1, saw_sel}), 16'h1);
		chk(resp_rdata_ff, RD_PAT);
		chk(16'(shared_pin_out_ff[0]), 16'h0);
		bank_en <= 2'b10;
	endtask

	task automatic t_async();
		xfer(1'b0, 1'b0, 26'h0812346, 16'h0);
		chk(16'(oe_a[15:1]), 16'h11a3);
		chk(16'({saw_oe, saw_wr, saw_sel}), 16'h4);
		chk(resp_rdata_ff, RD_PAT);
		chk(16'(ncyc >= 6), 16'h1);
		xfer(1'b1, 1'b0, 26'h0800008, 16'hbe1d);
		chk(16'({saw_wr, saw_oe}), 16'h2);
		chk(dout, 16'hbe1d);
		wait_cyc <= 4'h1;
		xfer(1'b0, 1'b0, 26'h1000004, 16'h0);
		chk(resp_rdata_ff, {8'h00, RD_PAT[15:8]});
		xfer(1'b1, 1'b1, 26'h1800002, 16'h00e1);
		chk(dout, 16'he1e1);
		dflt_wide <= 1'b1;
		xfer(1'b0, 1'b0, 26'h1800002, 16'h0);
		chk(resp_rdata_ff, RD_PAT);
	endtask

	task automatic t_gpio();
		@(posedge mclk);
		func_gpio <= 3'b011;
		pin_drv <= 2'b10;
		repeat (3) @(posedge mclk);
		#1;
		chk(16'(shared_pin_oe_ff[1:0]), 16'h0);
		chk(16'(gpio_in_ff), 16'h6);
		@(posedge mclk);
		gpio_oe <= 3'b011;
		gpio_out <= 3'b001;
		repeat (2) @(posedge mclk);
		#1;
		chk(16'(shared_pin_out_ff[1:0]), 16'h1);
		chk(16'(gpio_in_ff[1:0]), 16'h1);
		@(posedge mclk);
		func_gpio <= 3'b000;
		repeat (2) @(posedge mclk);
		#1;
		chk(16'(shared_pin_oe_ff), 16'h3);
	endtask

	// reset, fixed configuration, then the scenarios in turn
	initial begin
		{req_valid, req_write, req_byte, req_addr, req_wdata, dflt_wide} = '0;
		{func_gpio, gpio_out, gpio_oe, pin_drv} = '0;
		{cs_en, cs_wide, bank_en} = 6'b11_01_10;
		{cs0_base, cs1_base, wait_cyc} = {3'h1, 3'h2, 4'h6};
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_sdram();
		t_async();
		t_gpio();
		end_of_test();
	end
endmodule

`default_nettype wire
